// File: include/lbc_pkg.sv
package lbc_pkg;

    // Pulse modulation states
    typedef enum logic [1:0] {
        LBC_PFM_IDLE,
        LBC_PFM_ON,
        LBC_PFM_OFF
    } lbc_pfm_t;

    // Active peak current limit step
    typedef enum logic [1:0] {
        LBC_PEAK_CURRENT_LIMIT_QUARTER,
        LBC_PEAK_CURRENT_LIMIT_HALF,
        LBC_PEAK_CURRENT_LIMIT_FULL
    } lbc_peak_current_limit_t;

endpackage

// File: include/lbc_qual_if.sv
`timescale 1ns/10ps
// Enable qualifier to core link
interface lbc_qual_if;
    logic ctrl_s;
    logic enabled;
    logic en_start;
    modport qual (input ctrl_s, output enabled, output en_start);
    modport core (output ctrl_s, input enabled, input en_start);
endinterface

// File: include/lbc_regs.svh
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH

// Core clock rate
`define LBC_CLK_MHZ 40

// Times in ns as specified
`define LBC_T_EN_NS 500000
`define LBC_T_DIS_NS 32000000
`define LBC_T_ON_MAX_NS 4500
`define LBC_T_OFF_MIN_NS 400
`define LBC_T_BLANK_NS 400

// Soft-start step length in switch cycles
`define LBC_SS_STEP 256

// Least times round up, longest times round down
`define LBC_CYC_UP(ns) ((((ns) * `LBC_CLK_MHZ) + 999) / 1000)
`define LBC_CYC_DN(ns) (((ns) * `LBC_CLK_MHZ) / 1000)

`endif

// File: rtl/lbc_ctrl_qual.sv
`timescale 1ns/10ps
`include "lbc_regs.svh"
module lbc_ctrl_qual
    import lbc_pkg::*;
#(
    parameter int unsigned EN_CYC = `LBC_CYC_UP(`LBC_T_EN_NS),
    parameter int unsigned DIS_CYC = `LBC_CYC_DN(`LBC_T_DIS_NS)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    lbc_qual_if.qual q
);

    localparam logic [20:0] RUN_MAX = 21'h1fffff;
    localparam logic [20:0] EN_LAST = 21'(EN_CYC - 1);
    localparam logic [20:0] DIS_LAST = 21'(DIS_CYC - 1);

    logic lvl_q;
    logic [20:0] run_q;
    logic enabled_q;
    logic en_start_q;

    ////////////////////////////////////////////////////////////////
    // Cycles spent at the current input level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= 1'b0;
            run_q <= 21'h000000;
        end else begin
            lvl_q <= q.ctrl_s;
            if (q.ctrl_s != lvl_q) begin
                run_q <= 21'h000000;
            end else if (run_q != RUN_MAX) begin
                run_q <= run_q + 21'h000001;
            end
        end
    end

    // Enable after long high, disable after long low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enabled_q <= 1'b0;
            en_start_q <= 1'b0;
        end else begin
            en_start_q <= 1'b0;
            if (!enabled_q && q.ctrl_s && lvl_q && run_q == EN_LAST) begin
                enabled_q <= 1'b1;
                en_start_q <= 1'b1;
            end else if (enabled_q && !q.ctrl_s && !lvl_q && run_q == DIS_LAST) begin
                enabled_q <= 1'b0;
            end
        end
    end

    assign q.enabled = enabled_q;
    assign q.en_start = en_start_q;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    en_qual_a: assert property ($rose(enabled_q) |-> $past(q.ctrl_s) && $past(run_q) == EN_LAST)
        else $error("enable without qualified high time");
    dis_qual_a: assert property ($fell(enabled_q) |-> !$past(q.ctrl_s) && $past(run_q) == DIS_LAST)
        else $error("disable without qualified low time");
    start_pulse_a: assert property (en_start_q |-> $rose(enabled_q) ##1 !en_start_q)
        else $error("start pulse not tied to enable edge");

endmodule // lbc_ctrl_qual

// File: rtl/lbc_top.sv
`timescale 1ns/10ps
`include "lbc_regs.svh"
module lbc_top
    import lbc_pkg::*;
#(
    parameter int unsigned EN_CYC = `LBC_CYC_UP(`LBC_T_EN_NS),
    parameter int unsigned DIS_CYC = `LBC_CYC_DN(`LBC_T_DIS_NS)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic brightness_ctrl_i,
    input wire logic current_sense_feedback_low_i,
    input wire logic peak_current_limit_hit_i,
    input wire logic overvoltage_sense_high_i,
    input wire logic undervoltage_i,
    input wire logic over_temp_i,
    output logic main_power_switch_o,
    output logic led_ground_switch_o,
    output lbc_peak_current_limit_t peak_current_limit_o,
    output logic enabled_o
);

    localparam logic [7:0] TON_CYC = 8'(`LBC_CYC_DN(`LBC_T_ON_MAX_NS));
    localparam logic [7:0] TOFF_CYC = 8'(`LBC_CYC_UP(`LBC_T_OFF_MIN_NS));
    localparam logic [7:0] BLANK_CYC = 8'(`LBC_CYC_UP(`LBC_T_BLANK_NS));
    localparam logic [9:0] SS_STEP = 10'(`LBC_SS_STEP);
    localparam logic [9:0] SS_DONE = 10'(2 * `LBC_SS_STEP);

    // Soft-start count to limit step
    function automatic lbc_peak_current_limit_t peak_current_limit_step(input logic [9:0] cnt);
        if (cnt < SS_STEP) begin
            return LBC_PEAK_CURRENT_LIMIT_QUARTER;
        end else if (cnt < SS_DONE) begin
            return LBC_PEAK_CURRENT_LIMIT_HALF;
        end
        return LBC_PEAK_CURRENT_LIMIT_FULL;
    endfunction

    logic [5:0] raw;
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic fb_low_s;
    logic peak_current_limit_hit_s;
    logic ovp_s;
    logic uvlo_s;
    logic otp_s;
    logic hard_fault;
    logic run;
    logic led_close;
    logic fb_ok;
    lbc_pfm_t state_q;
    logic main_q;
    logic led_q;
    logic [7:0] tmr_q;
    logic [7:0] blank_q;
    logic [9:0] ss_cnt_q;
    lbc_peak_current_limit_t peak_current_limit_q;
    logic enabled_q;
    lbc_qual_if qif ();

    ////////////////////////////////////////////////////////////////
    // Two-stage synchronizers on all pin inputs
    assign raw = {brightness_ctrl_i, current_sense_feedback_low_i, peak_current_limit_hit_i,
                  overvoltage_sense_high_i, undervoltage_i, over_temp_i};

    for (genvar i = 0; i < 6; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= raw[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    assign qif.ctrl_s = s2_q[5];
    assign fb_low_s = s2_q[4];
    assign peak_current_limit_hit_s = s2_q[3];
    assign ovp_s = s2_q[2];
    assign uvlo_s = s2_q[1];
    assign otp_s = s2_q[0];

    ////////////////////////////////////////////////////////////////
    // Enable and shutdown qualification
    lbc_ctrl_qual #(
        .EN_CYC(EN_CYC),
        .DIS_CYC(DIS_CYC)
    ) u_qual (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .q(qif.qual)
    );

    // Gating terms
    assign hard_fault = uvlo_s || otp_s;
    assign run = qif.enabled && !hard_fault && !ovp_s;
    assign led_close = qif.enabled && qif.ctrl_s && !hard_fault && !led_q;
    // Feedback taken with the LED switch still open is stale, so the closing edge is blanked too
    assign fb_ok = fb_low_s && blank_q == 8'h00 && !led_close;

    ////////////////////////////////////////////////////////////////
    // LED ground switch follows input while enabled and no undervoltage or over-temp
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_q <= 1'b0;
        end else begin
            led_q <= qif.enabled && qif.ctrl_s && !hard_fault;
        end
    end

    // Feedback blanking after LED switch closes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blank_q <= 8'h00;
        end else if (led_close) begin
            blank_q <= BLANK_CYC;
        end else if (blank_q != 8'h00) begin
            blank_q <= blank_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Peak-current pulse modulation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= LBC_PFM_IDLE;
            main_q <= 1'b0;
            tmr_q <= 8'h00;
        end else if (!run) begin
            state_q <= (state_q == LBC_PFM_ON) ? LBC_PFM_OFF : state_q;
            main_q <= 1'b0;
            tmr_q <= (state_q == LBC_PFM_ON) ? 8'h00 : tmr_q;
        end else begin
            case (state_q)
                LBC_PFM_IDLE: begin
                    if (fb_ok) begin
                        state_q <= LBC_PFM_ON;
                        main_q <= 1'b1;
                        tmr_q <= 8'h01;
                    end
                end
                LBC_PFM_ON: begin
                    if (peak_current_limit_hit_s || tmr_q == TON_CYC) begin
                        state_q <= LBC_PFM_OFF;
                        main_q <= 1'b0;
                        tmr_q <= 8'h00;
                    end else begin
                        tmr_q <= tmr_q + 8'h01;
                    end
                end
                LBC_PFM_OFF: begin
                    if (tmr_q >= TOFF_CYC - 8'h01) begin
                        state_q <= LBC_PFM_IDLE;
                    end else begin
                        tmr_q <= tmr_q + 8'h01;
                    end
                end
                default: begin
                    state_q <= LBC_PFM_IDLE;
                    main_q <= 1'b0;
                    tmr_q <= 8'h00;
                end
            endcase
        end
    end

    // Off timer waits while held off, so the minimum off time is still served after
    ////////////////////////////////////////////////////////////////
    // Soft-start switch cycle count and limit step
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ss_cnt_q <= 10'h000;
        end else if (qif.en_start || !qif.enabled) begin
            ss_cnt_q <= 10'h000;
        end else if (run && state_q == LBC_PFM_IDLE && fb_ok && ss_cnt_q != SS_DONE) begin
            ss_cnt_q <= ss_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            peak_current_limit_q <= LBC_PEAK_CURRENT_LIMIT_QUARTER;
            enabled_q <= 1'b0;
        end else begin
            peak_current_limit_q <= peak_current_limit_step(ss_cnt_q);
            enabled_q <= qif.enabled;
        end
    end

    assign main_power_switch_o = main_q;
    assign led_ground_switch_o = led_q;
    assign peak_current_limit_o = peak_current_limit_q;
    assign enabled_o = enabled_q;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [8:0] on_run_q;
    logic [8:0] off_run_q;

    // Consecutive on and off cycle counters
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_run_q <= 9'h000;
            off_run_q <= 9'h000;
        end else begin
            on_run_q <= main_q ? on_run_q + 9'h001 : 9'h000;
            off_run_q <= main_q ? 9'h000 : ((off_run_q != 9'h1ff) ? off_run_q + 9'h001 : off_run_q);
        end
    end

    sequence s_no_turn_on;
        !$rose(main_q) [*8] ##1 !$rose(main_q) [*8] ##1 !$rose(main_q);
    endsequence

    turn_on_a: assert property (state_q == LBC_PFM_IDLE && run && fb_ok |=> main_q)
        else $error("main switch did not turn on");
    peak_off_a: assert property (state_q == LBC_PFM_ON && peak_current_limit_hit_s |=> !main_q)
        else $error("main switch stayed on past peak limit");
    max_on_a: assert property (on_run_q <= 9'(TON_CYC))
        else $error("main switch on-time too long");
    min_off_a: assert property ($rose(main_q) |-> $past(off_run_q) >= 9'(TOFF_CYC))
        else $error("main switch off-time too short");
    ss_full_a: assert property ($past(ss_cnt_q) >= SS_DONE |-> peak_current_limit_q == LBC_PEAK_CURRENT_LIMIT_FULL)
        else $error("limit not full after soft-start");
    ss_restart_a: assert property (qif.en_start |=> ss_cnt_q == 10'h000 ##1 peak_current_limit_q == LBC_PEAK_CURRENT_LIMIT_QUARTER)
        else $error("soft-start not restarted");
    led_follow_a: assert property (qif.enabled && qif.ctrl_s && !hard_fault |=> led_q)
        else $error("LED switch did not follow input");
    led_open_a: assert property (!qif.enabled |=> !led_q && !main_q)
        else $error("switches not open while disabled");
    blank_fb_a: assert property ($rose(led_q) |-> s_no_turn_on)
        else $error("main switch turned on during blanking");
    ovp_hold_a: assert property (ovp_s |=> !main_q)
        else $error("main switch on during overvoltage");
    uvlo_open_a: assert property (uvlo_s |=> !main_q && !led_q)
        else $error("switches not open in undervoltage");
    thermal_open_a: assert property (otp_s |=> !main_q && !led_q)
        else $error("switches not open in thermal shutdown");

endmodule // lbc_top

// File: verif/lbc_host_pwm.sv
`timescale 1ns/10ps
// Host brightness source: steady level or a repeating pulse train
module lbc_host_pwm (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic level_i,
    input wire logic [7:0] high_cyc_i,
    input wire logic [7:0] low_cyc_i,
    output logic ctrl_o
);
    logic ctrl_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    // Steady level passes straight through, so a level change lands on the edge it is set
    assign ctrl_o = run_i ? ctrl_q : level_i;
    // Pin always driven; low phase kept far below shutdown time
    always @(negedge clk_i) begin
        if (!run_i) begin
            ctrl_q <= level_i;
            cnt_q <= 8'h00;
        end else if (cnt_q >= (ctrl_q ? high_cyc_i : low_cyc_i) - 8'h01) begin
            ctrl_q <= !ctrl_q;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // lbc_host_pwm

// File: verif/test_lbc_top.sv
`timescale 1ns/10ps
module test_lbc_top;
    import lbc_pkg::*;
    localparam int unsigned EN_C = 20;
    localparam int unsigned DIS_C = 50;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic fb_low = 1'b0, peak_hit = 1'b0, overvoltage_sense = 1'b0, uv = 1'b0, ot = 1'b0;
    logic run = 1'b0, level = 1'b0;
    logic ctrl, main_sw, led_sw, en;
    lbc_peak_current_limit_t lim;
    logic [2:0] ctrl_hist = 3'h0;
    int n_errors = 0, tests_run = 0, cycles = 0, n, k;
    // Rows: overvoltage, undervoltage, over-temp, expected main, expected LED
    logic [4:0] rows [0:6] = '{5'h03, 5'h11, 5'h03, 5'h08, 5'h03, 5'h04, 5'h03};

    //////////////////////////////////////////////////
    // Clock
    always #12.5 clk_i = ~clk_i;

    lbc_top #(.EN_CYC(EN_C), .DIS_CYC(DIS_C)) u_lbc_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .brightness_ctrl_i(ctrl),
        .current_sense_feedback_low_i(fb_low), .peak_current_limit_hit_i(peak_hit),
        .overvoltage_sense_high_i(overvoltage_sense), .undervoltage_i(uv), .over_temp_i(ot),
        .main_power_switch_o(main_sw), .led_ground_switch_o(led_sw),
        .peak_current_limit_o(lim), .enabled_o(en));

    lbc_host_pwm u_lbc_host_pwm (.clk_i(clk_i), .run_i(run), .level_i(level),
        .high_cyc_i(8'h08), .low_cyc_i(8'h0c), .ctrl_o(ctrl));

    // Input history for the LED follow check
    always @(posedge clk_i) begin
        ctrl_hist <= {ctrl_hist[1:0], ctrl};
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    //////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Count falling edges until enable, main or LED reaches a level
    task automatic wait_for(input int sel, input logic val, input int lim_c, output int cnt);
        cnt = 0;
        while ((sel == 0 ? en : (sel == 1 ? main_sw : led_sw)) !== val && cnt < lim_c) begin
            @(negedge clk_i);
            cnt++;
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_i);
        check("lim_in_reset", lim, LBC_PEAK_CURRENT_LIMIT_QUARTER);
        check("outs_in_reset", {main_sw, led_sw, en}, 3'h0);
        rst_n_i = 1'b1;
        level = 1'b1;
        repeat (EN_C - 4) @(negedge clk_i);
        level = 1'b0;
        wait_for(0, 1'b1, 30, n);
        check("short_pulse_en", en, 1'b0);
        level = 1'b1;
        wait_for(0, 1'b1, EN_C + 10, n);
        check("enable_delay", n >= EN_C && n <= EN_C + 6, 1'b1);
        check("led_on_enable", led_sw, 1'b1);
        fb_low = 1'b1;
        for (k = 0; k < 7; k++) begin
            {overvoltage_sense, uv, ot} = rows[k][4:2];
            repeat (30) @(negedge clk_i);
            check("row_main", main_sw, rows[k][1]);
            check("row_led", led_sw, rows[k][0]);
        end
        wait_for(1, 1'b0, 200, n);
        wait_for(1, 1'b1, 40, n);
        wait_for(1, 1'b0, 200, n);
        check("max_on_time", n, 180);
        fb_low = 1'b0;
        wait_for(1, 1'b1, 40, n);
        check("off_fb_high", main_sw, 1'b0);
        fb_low = 1'b1;
        wait_for(1, 1'b1, 10, n);
        check("on_fb_low", main_sw, 1'b1);
        level = 1'b0;
        wait_for(0, 1'b0, DIS_C + 10, n);
        check("disable_delay", n >= DIS_C && n <= DIS_C + 6, 1'b1);
        check("off_disabled", {main_sw, led_sw}, 2'h0);
        level = 1'b1;
        wait_for(0, 1'b1, EN_C + 10, n);
        for (k = 0; k < 513; k++) begin
            wait_for(1, 1'b1, 60, n);
            check("soft_step", lim, k < 256 ? LBC_PEAK_CURRENT_LIMIT_QUARTER : (k < 512 ? LBC_PEAK_CURRENT_LIMIT_HALF : LBC_PEAK_CURRENT_LIMIT_FULL));
            peak_hit = 1'b1;
            wait_for(1, 1'b0, 10, n);
            check("peak_off", n <= 4, 1'b1);
            peak_hit = 1'b0;
            wait_for(1, 1'b1, 40, n);
            check("min_off", n >= 16, 1'b1);
        end
        // Blanking after the LED switch closes
        fb_low = 1'b0;
        wait_for(1, 1'b0, 200, n);
        level = 1'b0;
        repeat (10) @(negedge clk_i);
        level = 1'b1;
        fb_low = 1'b1;
        wait_for(2, 1'b1, 10, n);
        check("led_rise", n, 3);
        wait_for(1, 1'b1, 40, n);
        check("blank_hold", n >= 15, 1'b1);
        // Pulse train while enabled
        run = 1'b1;
        repeat (5) @(negedge clk_i);
        for (k = 0; k < 80; k++) begin
            @(negedge clk_i);
            check("led_follow", led_sw, ctrl_hist[2]);
        end
        check("still_enabled", en, 1'b1);
        run = 1'b0;
        tally_and_finish();
    end
endmodule // test_lbc_top
